// file: abort_ctl_map.vh
/*
 * Constants for the pipeline exception and abort controller.
 * Assumes a five-stage pipeline (fetch, decode, execute, memory, writeback)
 * whose stage registers, divide unit and refill logic share one clock.
 */
// Contract
// - Uncached accesses follow the refill sequence
// - Excepting instruction writes no result
// - Cancel younger instructions, redirect fetch
// - Exceptions normally taken in memory stage
// - Four fetch/debug traps taken in execute
// - Resets accepted in any stage
// - Destinationless divide overlaps later instructions
// - Divide completes despite younger exception
// - Refill completes on non-fatal exception (data refill only; the sequencer leaves RF_FETCH on any exception)
// - Bus error or reset aborts refill
// - Stall consumer of missed load in execute
// - Fetch waits for data refill end
`ifndef ABORT_CTL_MAP_VH
`define ABORT_CTL_MAP_VH

// Execute-stage trap cause bit positions
`define EX_TRAP_STEP      0
`define EX_TRAP_BREAK     1
`define EX_TRAP_ADDR      2
`define EX_TRAP_XLATE     3
`define EX_TRAP_W         4

// Exception cause codes reported with the redirect
`define CAUSE_W           4
`define CAUSE_NONE        4'h0
`define CAUSE_MEM         4'h1
`define CAUSE_STEP        4'h2
`define CAUSE_BREAK       4'h3
`define CAUSE_ADDR        4'h4
`define CAUSE_XLATE       4'h5
`define CAUSE_BUS_ERR     4'h6
`define CAUSE_SOFT_RST    4'h7
`define CAUSE_HARD_RST    4'h8

// Refill sequencer states
`define RF_IDLE           2'h0
`define RF_BUSY           2'h1
`define RF_FETCH          2'h2

// Register number width
`define REG_W             5

`endif

// file: stage_valid_bank.v
/*
 * Valid-bit bank for the pipeline stage registers.
 * Assumes the controller supplies per-stage kill and hold; stage 0 is fetch.
 */
`timescale 1ns/1ns
module stage_valid_bank #(
    parameter STAGES = 5                       // Pipeline depth
) (
    // Clock and reset
    input  wire              i_clock,
    input  wire              i_rst,
    // Control
    input  wire              i_issue,          // New instruction enters fetch
    input  wire [STAGES-1:0] i_kill,           // Squash per stage
    input  wire [STAGES-1:0] i_hold,           // Stage keeps its content
    // State
    output reg  [STAGES-1:0] o_valid           // Registered valid bits
);

    integer k;

    // Advance valid bits, honouring hold and kill per stage
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_valid <= {STAGES{1'b0}};
        end else begin
            for (k = 0; k < STAGES; k = k + 1) begin
                if (i_kill[k]) begin
                    o_valid[k] <= 1'b0;
                end else if (i_hold[k]) begin
                    o_valid[k] <= o_valid[k];
                end else if (k == 0) begin
                    o_valid[k] <= i_issue;
                end else if (i_hold[k-1]) begin
                    // Bubble when the stage behind is held
                    o_valid[k] <= 1'b0;
                end else begin
                    o_valid[k] <= o_valid[k-1] & ~i_kill[k-1];
                end
            end
        end
    end

endmodule // stage_valid_bank

// file: exception_abort_ctl.v
/*
 * Pipeline exception and abort controller: picks the exception to take,
 * squashes the excepting and younger instructions, redirects fetch, lets
 * divides and non-fatal refills finish, sequences refills and uncached
 * accesses, and interlocks on missed loads and refill conflicts.
 * Assumes stage logic, divide unit and refill engine share i_clock;
 * reset pins arrive from outside and are synchronised here.
 */
`timescale 1ns/1ns
`include "abort_ctl_map.vh"
module exception_abort_ctl #(
    parameter STAGES = 5                       // Fetch..writeback
) (
    // Clock and reset
    input  wire                 i_clock,
    input  wire                 i_rst,
    // Asynchronous reset requests (pins)
    input  wire                 i_hard_reset_pin,
    input  wire                 i_soft_reset_pin,
    // Fetch side
    input  wire                 i_fetch_req,   // Fetch wants to issue
    input  wire                 i_fetch_uncached,
    input  wire                 i_icache_miss,
    // Execute-stage traps on the instruction in execute
    input  wire [`EX_TRAP_W-1:0] i_ex_trap,
    input  wire [`REG_W-1:0]    i_ex_src_a,    // Execute source registers
    input  wire [`REG_W-1:0]    i_ex_src_b,
    input  wire                 i_ex_is_div,   // Destinationless divide start
    // Memory-stage status
    input  wire                 i_mem_exc,     // Any memory-stage exception
    input  wire                 i_mem_load,
    input  wire                 i_mem_store,
    input  wire                 i_mem_uncached,
    input  wire                 i_dcache_miss,
    input  wire [`REG_W-1:0]    i_mem_dest,
    // Divide unit and refill engine status
    input  wire                 i_div_done,
    input  wire                 i_refill_done, // Last word of refill
    input  wire                 i_refill_data, // Load word returned
    input  wire                 i_bus_error,
    // Pipeline control
    output reg  [STAGES-1:0]    o_stage_valid,
    output reg  [STAGES-1:0]    o_stage_kill,
    output reg                  o_wb_enable,   // Architectural write allowed
    output reg                  o_ex_stall,
    output reg                  o_fetch_stall,
    // Redirect to handler
    output reg                  o_redirect,
    output reg  [`CAUSE_W-1:0]  o_cause,
    // Divide and refill control
    output reg                  o_div_busy,
    output reg                  o_div_abort,
    output reg                  o_refill_start,
    output reg                  o_refill_abort,
    output reg                  o_fetch_start
);

    localparam FE = 0, EX = 2, ME = 3, WB = 4;

    // Synchronised reset pins
    reg                 hard_meta_reg, hard_sync_reg;
    reg                 soft_meta_reg, soft_sync_reg;
    // Refill sequencer
    reg  [1:0]          rf_state_reg, rf_state_next;
    reg                 load_pend_reg;            // Missed load outstanding
    reg  [`REG_W-1:0]   load_dest_reg;            // Its destination
    reg                 div_busy_reg;
    // Combinational decisions
    reg  [`CAUSE_W-1:0] cause_sel;
    reg                 take_exc;
    reg                 fatal;
    reg  [STAGES-1:0]   kill_mask;
    reg  [STAGES-1:0]   hold_mask;
    reg                 ex_stall_c;
    reg                 fetch_stall_c;
    wire [STAGES-1:0]   valid_w;

    // Encodes execute-stage trap to a cause, step highest
    function [`CAUSE_W-1:0] ex_cause;
        input [`EX_TRAP_W-1:0] t;
        begin
            if (t[`EX_TRAP_STEP])
                ex_cause = `CAUSE_STEP;
            else if (t[`EX_TRAP_BREAK])
                ex_cause = `CAUSE_BREAK;
            else if (t[`EX_TRAP_ADDR])
                ex_cause = `CAUSE_ADDR;
            else if (t[`EX_TRAP_XLATE])
                ex_cause = `CAUSE_XLATE;
            else
                ex_cause = `CAUSE_NONE;
        end
    endfunction

    // Matches a source register against the pending load
    function hits_load;
        input [`REG_W-1:0] src;
        begin
            hits_load = load_pend_reg && (src == load_dest_reg) && (src != {`REG_W{1'b0}});
        end
    endfunction

    // Two-flop synchronisers for the reset pins
    always @(posedge i_clock) begin
        if (i_rst) begin
            hard_meta_reg <= 1'b0;
            hard_sync_reg <= 1'b0;
            soft_meta_reg <= 1'b0;
            soft_sync_reg <= 1'b0;
        end else begin
            hard_meta_reg <= i_hard_reset_pin;
            hard_sync_reg <= hard_meta_reg;
            soft_meta_reg <= i_soft_reset_pin;
            soft_sync_reg <= soft_meta_reg;
        end
    end

    // Exception selection and squash mask
    always @* begin
        cause_sel = `CAUSE_NONE;
        kill_mask = {STAGES{1'b0}};
        fatal     = 1'b0;
        if (hard_sync_reg || soft_sync_reg) begin
            cause_sel = hard_sync_reg ? `CAUSE_HARD_RST : `CAUSE_SOFT_RST;
            kill_mask = {STAGES{1'b1}};
            fatal     = 1'b1;
        end else if (i_bus_error) begin
            // Bus error is fatal; squash all not yet written back
            cause_sel = `CAUSE_BUS_ERR;
            kill_mask = {{(STAGES-WB){1'b0}}, {WB{1'b1}}};
            fatal     = 1'b1;
        end else if (i_mem_exc && valid_w[ME]) begin
            cause_sel = `CAUSE_MEM;
            kill_mask = {{(STAGES-ME-1){1'b0}}, {(ME+1){1'b1}}};
        end else if ((|i_ex_trap) && valid_w[EX]) begin
            cause_sel = ex_cause(i_ex_trap);
            kill_mask = {{(STAGES-EX-1){1'b0}}, {(EX+1){1'b1}}};
        end
        take_exc = (cause_sel != `CAUSE_NONE);
    end

    // Interlocks: load-use and refill conflicts
    always @* begin
        ex_stall_c = valid_w[EX] && !take_exc &&
                     (hits_load(i_ex_src_a) || hits_load(i_ex_src_b)) && !i_refill_data;
        fetch_stall_c = (rf_state_reg == `RF_BUSY) && i_fetch_req &&
                        (i_icache_miss || i_fetch_uncached);
        hold_mask = {STAGES{1'b0}};
        if (ex_stall_c) begin
            hold_mask = {{(STAGES-EX-1){1'b0}}, {(EX+1){1'b1}}};
        end else if (fetch_stall_c) begin
            hold_mask[FE] = 1'b1;
        end
    end

    // Refill sequencer next state
    always @* begin
        rf_state_next = rf_state_reg;
        case (rf_state_reg)
            `RF_IDLE: begin
                if (!take_exc && valid_w[ME] &&
                    ((i_mem_load && (i_dcache_miss || i_mem_uncached)) ||
                     (i_mem_store && i_mem_uncached)))
                    rf_state_next = `RF_BUSY;
                else if (i_fetch_req && (i_icache_miss || i_fetch_uncached) && !take_exc)
                    rf_state_next = `RF_FETCH;
            end
            `RF_BUSY: begin
                if (take_exc && fatal)
                    rf_state_next = `RF_IDLE;
                else if (i_refill_done)
                    rf_state_next = (i_fetch_req && (i_icache_miss || i_fetch_uncached))
                                    ? `RF_FETCH : `RF_IDLE;
            end
            `RF_FETCH: begin
                if (i_refill_done || take_exc)
                    rf_state_next = `RF_IDLE;
            end
            default: rf_state_next = `RF_IDLE;
        endcase
    end

    // Sequencer, pending load and divide tracking
    always @(posedge i_clock) begin
        if (i_rst) begin
            rf_state_reg  <= `RF_IDLE;
            load_pend_reg <= 1'b0;
            load_dest_reg <= {`REG_W{1'b0}};
            div_busy_reg  <= 1'b0;
        end else begin
            rf_state_reg <= rf_state_next;
            if (take_exc && fatal) begin
                load_pend_reg <= 1'b0;
            end else if (rf_state_reg == `RF_IDLE && rf_state_next == `RF_BUSY
                         && i_mem_load) begin
                load_pend_reg <= 1'b1;
                load_dest_reg <= i_mem_dest;
            end else if (i_refill_data) begin
                load_pend_reg <= 1'b0;
            end
            if (take_exc && fatal)
                div_busy_reg <= 1'b0;
            else if (i_ex_is_div && valid_w[EX] && !take_exc && !ex_stall_c)
                div_busy_reg <= 1'b1;
            else if (i_div_done)
                div_busy_reg <= 1'b0;
        end
    end

    // Registered control outputs
    always @(posedge i_clock) begin
        if (i_rst) begin
            o_stage_valid  <= {STAGES{1'b0}};
            o_stage_kill   <= {STAGES{1'b0}};
            o_wb_enable    <= 1'b0;
            o_ex_stall     <= 1'b0;
            o_fetch_stall  <= 1'b0;
            o_redirect     <= 1'b0;
            o_cause        <= `CAUSE_NONE;
            o_div_busy     <= 1'b0;
            o_div_abort    <= 1'b0;
            o_refill_start <= 1'b0;
            o_refill_abort <= 1'b0;
            o_fetch_start  <= 1'b0;
        end else begin
            o_stage_valid  <= valid_w;
            o_stage_kill   <= kill_mask;
            o_wb_enable    <= valid_w[WB] && !(take_exc && fatal);
            o_ex_stall     <= ex_stall_c;
            o_fetch_stall  <= fetch_stall_c;
            o_redirect     <= take_exc;
            o_cause        <= cause_sel;
            o_div_busy     <= div_busy_reg;
            o_div_abort    <= take_exc && fatal && div_busy_reg;
            o_refill_start <= (rf_state_reg == `RF_IDLE) && (rf_state_next == `RF_BUSY);
            o_refill_abort <= (rf_state_reg != `RF_IDLE) && take_exc && fatal;
            o_fetch_start  <= (rf_state_reg != `RF_FETCH) && (rf_state_next == `RF_FETCH);
        end
    end

    // Stage valid bits with squash and hold
    stage_valid_bank #(
        .STAGES (STAGES)
    ) u_valid (
        .i_clock (i_clock),
        .i_rst   (i_rst),
        .i_issue (i_fetch_req && !take_exc),
        .i_kill  (kill_mask),
        .i_hold  (hold_mask),
        .o_valid (valid_w)
    );

endmodule // exception_abort_ctl

// file: exception_abort_ctl_asserts.sv
/* Checker for the exception abort controller top ports.
   Assumes binding from the bench and one core clock. */
`timescale 1ns/1ns
`include "abort_ctl_map.vh"
module abort_checker #(
    parameter STAGES = 5                      // Pipeline depth
) (
    // Clock and reset
    input wire                   i_clock,
    input wire                   i_rst,
    // Causes
    input wire                   i_hard_reset_pin,
    input wire [`EX_TRAP_W-1:0]  i_ex_trap,
    input wire                   i_mem_exc,
    input wire                   i_bus_error,
    input wire                   i_refill_done,
    // Decisions
    input wire [STAGES-1:0]      o_stage_kill,
    input wire                   o_redirect,
    input wire [`CAUSE_W-1:0]    o_cause,
    input wire                   o_div_busy,
    input wire                   o_div_abort,
    input wire                   o_refill_start,
    input wire                   o_refill_abort,
    input wire                   o_fetch_start
);
    reg busy_reg;                             // Data refill in flight
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // Follow a refill from start pulse to its last word or a bus fault
    always @(posedge i_clock) begin
        if (i_rst || i_refill_done || i_bus_error) busy_reg <= 1'h0;
        else if (o_refill_start) busy_reg <= 1'h1;
    end
    // Step trap wins, then break, address, translation
    function [`CAUSE_W-1:0] trap_cause(input [`EX_TRAP_W-1:0] t);
        trap_cause = t[0] ? `CAUSE_STEP : t[1] ? `CAUSE_BREAK :
                     t[2] ? `CAUSE_ADDR : `CAUSE_XLATE;
    endfunction
    mem_kill_a: assert property (o_redirect && o_cause == `CAUSE_MEM
        |-> $past(i_mem_exc) && o_stage_kill == 5'h0f) else $error("Memory abort wrong");
    ex_kill_a: assert property (o_redirect && o_cause inside
        {[`CAUSE_STEP:`CAUSE_XLATE]} |-> o_stage_kill == 5'h07) else $error("Trap kill wrong");
    trap_order_a: assert property (o_redirect && o_cause inside
        {[`CAUSE_STEP:`CAUSE_XLATE]} |-> o_cause == trap_cause($past(i_ex_trap)))
        else $error("Trap priority wrong");
    redirect_once_a: assert property (o_redirect && o_cause != 4'h7 && o_cause != 4'h8
        |=> !o_redirect) else $error("Redirect repeated");
    cause_given_a: assert property (o_redirect
        |-> o_cause != `CAUSE_NONE && o_stage_kill != 5'h00) else $error("Redirect empty");
    fetch_wait_a: assert property (o_fetch_start |-> !busy_reg)
        else $error("Fetch started during refill");
    work_kept_a: assert property (o_redirect && o_cause inside {[4'h1:4'h5]}
        |-> !o_refill_abort && !o_div_abort) else $error("Non-fatal abort");
    refill_cut_a: assert property (i_bus_error && busy_reg |=> o_refill_abort)
        else $error("Refill not aborted");
    hard_rst_a: assert property ($rose(i_hard_reset_pin)
        |-> ##[1:4] o_redirect && o_cause == `CAUSE_HARD_RST) else $error("Reset not taken");
    cover property (o_redirect && o_cause == `CAUSE_MEM && busy_reg);
    cover property (o_refill_abort);
    cover property (o_redirect && o_div_busy);
endmodule // abort_checker

// file: pipe_partner.sv
/* Model of divide unit and refill engine facing the controller.
   Assumes start and busy come from the controller outputs. */
`timescale 1ns/1ns
module pipe_partner (
    // Clock and reset
    input wire       i_clock,
    input wire       i_rst,
    // Controller requests
    input wire       i_refill_start,
    input wire       i_fetch_start,           // Instruction refill request
    input wire       i_refill_abort,
    input wire       i_div_busy,
    input wire [3:0] i_lat,                   // Answer latency
    // Answers
    output reg       o_refill_data,
    output reg       o_refill_done,
    output reg       o_div_done
);
    reg [3:0] rf_cnt_reg;                     // Refill words left
    reg [3:0] dv_cnt_reg;                     // Divide cycles left
    reg       dv_sent_reg;                    // Done already given
    // Answer refills and divides after the chosen latency
    always @(posedge i_clock) begin
        o_refill_data <= 1'h0;
        o_refill_done <= 1'h0;
        o_div_done <= 1'h0;
        if (i_rst || i_refill_abort) rf_cnt_reg <= 4'h0;
        else if (i_refill_start || i_fetch_start) rf_cnt_reg <= i_lat;
        else if (rf_cnt_reg != 4'h0) begin
            rf_cnt_reg <= rf_cnt_reg - 4'h1;
            o_refill_data <= (rf_cnt_reg == i_lat);
            o_refill_done <= (rf_cnt_reg == 4'h1);
        end
        if (i_rst || !i_div_busy) begin
            dv_cnt_reg <= i_lat;
            dv_sent_reg <= 1'h0;
        end else if (dv_cnt_reg != 4'h0) dv_cnt_reg <= dv_cnt_reg - 4'h1;
        else if (!dv_sent_reg) begin
            o_div_done <= 1'h1;
            dv_sent_reg <= 1'h1;
        end
    end
endmodule // pipe_partner

// file: exception_abort_ctl_tb.sv
/* Scoreboard bench for the exception abort controller.
   Assumes the partner model and the checker bound below. */
`timescale 1ns/1ns
`include "abort_ctl_map.vh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin mismatches++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module exception_abort_ctl_tb;
    // Stimulus
    reg        i_clock = 1'h0, i_rst = 1'h1, i_hard_reset_pin = 1'h0, i_soft_reset_pin = 1'h0;
    reg        i_fetch_req = 1'h0, i_fetch_uncached = 1'h0, i_icache_miss = 1'h0;
    reg        i_mem_exc = 1'h0, i_mem_load = 1'h0, i_mem_store = 1'h0, i_mem_uncached = 1'h0;
    reg        i_dcache_miss = 1'h0, i_bus_error = 1'h0, i_ex_is_div = 1'h0;
    reg  [3:0] i_ex_trap = 4'h0, lat = 4'h1, e;
    reg  [4:0] i_ex_src_a = 5'h01, i_ex_src_b = 5'h00, i_mem_dest = 5'h1f;
    // Partner answers and design outputs
    wire       i_div_done, i_refill_done, i_refill_data;
    wire [4:0] o_stage_valid, o_stage_kill;
    wire [3:0] o_cause;
    wire       o_wb_enable, o_ex_stall, o_fetch_stall, o_redirect, o_div_busy;
    wire       o_div_abort, o_refill_start, o_refill_abort, o_fetch_start;
    reg  [3:0] exp_q[$];                      // Expected causes
    integer    mismatches = 0, checked = 0, k, j;
    exception_abort_ctl #(.STAGES(5)) dut (.i_clock, .i_rst, .i_hard_reset_pin,
        .i_soft_reset_pin, .i_fetch_req, .i_fetch_uncached, .i_icache_miss, .i_ex_trap,
        .i_ex_src_a, .i_ex_src_b, .i_ex_is_div, .i_mem_exc, .i_mem_load, .i_mem_store,
        .i_mem_uncached, .i_dcache_miss, .i_mem_dest, .i_div_done, .i_refill_done,
        .i_refill_data, .i_bus_error, .o_stage_valid, .o_stage_kill, .o_wb_enable,
        .o_ex_stall, .o_fetch_stall, .o_redirect, .o_cause, .o_div_busy, .o_div_abort,
        .o_refill_start, .o_refill_abort, .o_fetch_start);
    pipe_partner partner (.i_clock, .i_rst, .i_refill_start(o_refill_start),
        .i_fetch_start(o_fetch_start),
        .i_refill_abort(o_refill_abort), .i_div_busy(o_div_busy), .i_lat(lat),
        .o_refill_data(i_refill_data), .o_refill_done(i_refill_done), .o_div_done(i_div_done));
    always #50 i_clock = ~i_clock;
    // Each redirect takes the oldest expected cause
    always @(posedge i_clock) begin
        if (o_redirect === 1'b1 && exp_q.size() == 0) `CHK(o_redirect, 1'h0)
        else if (o_redirect === 1'b1) begin
            e = exp_q.pop_front();
            `CHK(o_cause, e)
        end
    end
    task cyc(input integer n);
        repeat (n) @(negedge i_clock);
    endtask
    // One-cycle exception, then refill the pipeline
    task fire(input [3:0] trap, input mem, input [3:0] cause);
        i_ex_trap = trap;
        i_mem_exc = mem;
        exp_q.push_back(cause);
        cyc(1);
        i_ex_trap = 4'h0;
        i_mem_exc = 1'h0;
        cyc(6);
    endtask
    // load miss or uncached load starts a refill
    task miss(input unc);
        i_mem_load = 1'h1;
        i_dcache_miss = !unc;
        i_mem_uncached = unc;
        cyc(1);
        i_mem_load = 1'h0;
        i_dcache_miss = 1'h0;
        i_mem_uncached = 1'h0;
        for (j = 0; j < 4 && o_refill_start !== 1'b1; j++) cyc(1);
        `CHK(o_refill_start, 1'h1)
    endtask
    task done(input string n);
        $display("Test %0s finished", n);
    endtask
    task report_and_stop;
        $display("Comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #300000;
        mismatches++;
        report_and_stop;
    end
    initial begin
        i_ex_src_b = 5'($urandom(32'h697e)) & 5'h0f;
        cyc(5);
        i_rst = 1'h0;
        i_fetch_req = 1'h1;
        cyc(6);
        // memory exception alone and beside a trap
        fire(4'h0, 1'h1, `CAUSE_MEM);
        fire(4'h1, 1'h1, `CAUSE_MEM);
        // every execute trap, random bits above it
        for (k = 0; k < 4; k++) fire(4'(($urandom << k) | (1 << k)), 1'h0, 4'(2 + k));
        done("priority");
        // slow refill survives an exception, fetch miss waits
        lat = 4'($urandom_range(14, 10));
        miss(1'h0);
        i_icache_miss = 1'h1;
        fire(4'h0, 1'h1, `CAUSE_MEM);
        for (j = 0; j < 40 && o_fetch_start !== 1'b1; j++) cyc(1);
        `CHK(o_fetch_start, 1'h1)
        i_icache_miss = 1'h0;
        cyc(20);
        // consumer of the missed load stalls in execute
        i_ex_src_a = 5'h1f;
        miss(1'h0);
        for (j = 0; j < 4 && o_ex_stall !== 1'b1; j++) cyc(1);
        `CHK(o_ex_stall, 1'h1)
        for (j = 0; j < 30 && o_ex_stall !== 1'b0; j++) cyc(1);
        `CHK(o_ex_stall, 1'h0)
        i_ex_src_a = 5'h01;
        cyc(20);
        // bus error cuts the refill short
        miss(1'h0);
        cyc(2);
        i_bus_error = 1'h1;
        exp_q.push_back(`CAUSE_BUS_ERR);
        cyc(1);
        i_bus_error = 1'h0;
        cyc(20);
        // Prompt uncached load
        lat = 4'h1;
        miss(1'h1);
        cyc(6);
        done("refill");
        // divide keeps running past a younger exception
        lat = 4'hc;
        i_ex_is_div = 1'h1;
        cyc(1);
        i_ex_is_div = 1'h0;
        cyc(1);
        fire(4'h0, 1'h1, `CAUSE_MEM);
        `CHK(o_div_busy, 1'h1)
        `CHK(o_ex_stall, 1'h0)
        for (j = 0; j < 30 && o_div_busy !== 1'b0; j++) cyc(1);
        `CHK(o_div_busy, 1'h0)
        done("divide");
        // reset pins taken at any time
        i_hard_reset_pin = 1'h1;
        exp_q.push_back(`CAUSE_HARD_RST);
        cyc(1);
        i_hard_reset_pin = 1'h0;
        cyc(10);
        i_soft_reset_pin = 1'h1;
        exp_q.push_back(`CAUSE_SOFT_RST);
        cyc(1);
        i_soft_reset_pin = 1'h0;
        cyc(10);
        `CHK(exp_q.size(), 0)
        done("reset");
        report_and_stop;
    end
endmodule // exception_abort_ctl_tb
bind exception_abort_ctl abort_checker #(.STAGES(STAGES)) chk (.i_clock, .i_rst,
    .i_hard_reset_pin, .i_ex_trap, .i_mem_exc, .i_bus_error, .i_refill_done, .o_stage_kill,
    .o_redirect, .o_cause, .o_div_busy, .o_div_abort, .o_refill_start, .o_refill_abort,
    .o_fetch_start);
